// [gpio_port.sv]
// Eight-pin GPIO port with APB registers, bypass and wire-OR pin interrupts.
`timescale 1ns/1ps
// Summary of operation
// - One enable bit per pin, same position.
// - Level mode interrupts while pin low.
// - Change mode interrupts when pin differs.
// - Data read captures last-read latch.
// - Disabled pin never drives interrupt.
// - Open-drain active-low, wire-ORed shared line.
// - Enabling with condition met asserts immediately.
// - Interrupt holds until a release cause.
// - Shared interrupt raised on line falling.
// - Data write sets drive unless bypassed.
// - Data read returns pin levels.
// - Serial function forces its pins bypass.
// - Bypass-select bit routes internal signal.
// - Unimplemented pin bits read zero.
// - Four-pin port uses low enables.
// - Analog mode pin reads zero.
// - Change select is config bit zero.
module gpio_port
  import gpio_port_pkg::*;
#(
  parameter int         PIN_COUNT = 8,     // Implemented pins, 4 or 8.
  parameter logic [7:0] PIN_MASK  = 8'hff  // Implemented pin positions.
)(
  input  wire logic              clock,          // System clock.
  input  wire logic              reset,          // Synchronous reset, active high.
  input  wire logic              psel,           // APB select.
  input  wire logic              penable,        // APB enable.
  input  wire logic              pwrite,         // APB direction.
  input  wire logic [ADDR_W-1:0] paddr,          // APB byte address.
  input  wire logic [31:0]       pwdata,         // APB write data.
  output logic      [31:0]       prdata,         // APB read data.
  output logic                   pready,         // APB ready.
  output logic                   pslverr,        // APB error.
  input  wire logic [7:0]        pin_in,         // Pin levels from input buffers.
  output logic      [7:0]        pin_out,        // Pin output data.
  output logic      [7:0]        drive_mode_low_bits,  // Drive mode bit 0 per pin.
  output logic      [7:0]        drive_mode_high_bits, // Drive mode bit 1 per pin.
  input  wire logic [7:0]        serial_force,   // Serial function owns these pins.
  input  wire logic [7:0]        alt_data,       // Internal bypass data.
  input  wire logic              irq_line_in,    // Level of shared interrupt wire.
  output logic                   irq_line_o,     // Shared line output value, always 0.
  output logic                   irq_line_oe,    // High while this port pulls low.
  output logic                   irq_event       // One-cycle shared interrupt pulse.
);
  initial begin
    if (!(PIN_COUNT == 4 || PIN_COUNT == 8)) begin
      $error("PIN_COUNT must be 4 or 8");
    end
  end

  // Enables above the pin count have no effect.
  localparam logic [7:0] LIVE_MASK = (PIN_COUNT == 4) ? (PIN_MASK & 8'h0f) : PIN_MASK;

  logic [7:0] data_reg;
  logic [7:0] irq_en_reg;
  logic [7:0] dm_low_reg;
  logic [7:0] dm_high_reg;
  logic [7:0] bypass_reg;
  logic       change_sel_reg;
  logic       line_prev_reg;
  logic [7:0] pin_level;
  logic [7:0] irq_assert;
  logic [7:0] pin_oe;
  logic       wr_en;
  logic       rd_en;
  logic       data_read;
  logic       addr_ok;
  logic [31:0] rdata_next;

  function automatic logic [31:0] widen(input logic [7:0] v);
    widen = {24'h00_0000, v & LIVE_MASK};
  endfunction : widen

  assign wr_en     = psel & penable & pwrite;
  assign rd_en     = psel & penable & ~pwrite;
  assign data_read = rd_en & (paddr == OFS_DATA);
  assign pready    = 1'b1;
  assign addr_ok   = (paddr == OFS_DATA) || (paddr == OFS_IRQ_EN) || (paddr == OFS_DRIVE_LOW) ||
                     (paddr == OFS_DRIVE_HIGH) || (paddr == OFS_BYPASS_SEL) ||
                     (paddr == OFS_IO_CONFIG) || (paddr == OFS_IRQ_STATUS);
  assign pslverr   = psel & penable & ~addr_ok;

  always_ff @(posedge clock) begin
    if (reset) begin
      data_reg <= RST_ZERO;
    end else if (wr_en && paddr == OFS_DATA) begin
      data_reg <= pwdata[7:0] & LIVE_MASK;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      irq_en_reg <= RST_ZERO;
    end else if (wr_en && paddr == OFS_IRQ_EN) begin
      irq_en_reg <= pwdata[7:0] & LIVE_MASK;
    end
  end

  // Drive modes reset to analog high impedance, so inputs start disabled.
  always_ff @(posedge clock) begin
    if (reset) begin
      dm_low_reg  <= RST_ZERO;
      dm_high_reg <= RST_DRIVE_HIGH;
    end else if (wr_en && paddr == OFS_DRIVE_LOW) begin
      dm_low_reg <= pwdata[7:0] & LIVE_MASK;
    end else if (wr_en && paddr == OFS_DRIVE_HIGH) begin
      dm_high_reg <= pwdata[7:0] & LIVE_MASK;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      bypass_reg <= RST_ZERO;
    end else if (wr_en && paddr == OFS_BYPASS_SEL) begin
      bypass_reg <= pwdata[7:0] & LIVE_MASK;
    end
  end

  // Change select lives in config bit 0.
  always_ff @(posedge clock) begin
    if (reset) begin
      change_sel_reg <= 1'b0;
    end else if (wr_en && paddr == OFS_IO_CONFIG) begin
      change_sel_reg <= pwdata[CHANGE_SEL_BIT];
    end
  end

  // Bypass mux; drive mode stays untouched.
  always_ff @(posedge clock) begin
    if (reset) begin
      pin_out <= RST_ZERO;
    end else begin
      pin_out <= ((bypass_reg | serial_force) & alt_data | ~(bypass_reg | serial_force) & data_reg) & LIVE_MASK;
    end
  end

  assign drive_mode_low_bits  = dm_low_reg;
  assign drive_mode_high_bits = dm_high_reg;

  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_pin
      gpio_pin_slice u_slice (
        .clock        (clock),
        .reset        (reset),
        .pin_raw      (pin_in[g]),
        .drive_mode   ({dm_high_reg[g], dm_low_reg[g]}),
        .irq_en       (irq_en_reg[g] & LIVE_MASK[g]),
        .change_sel   (change_sel_reg),
        .data_read    (data_read),
        .pin_level    (pin_level[g]),
        .irq_assert   (irq_assert[g]),
        .irq_out_n_oe (pin_oe[g])
      );
    end
  endgenerate

  assign irq_line_oe = |pin_oe;
  assign irq_line_o  = 1'b0;

  // Raise on high-to-low of shared line.
  always_ff @(posedge clock) begin
    if (reset) begin
      line_prev_reg <= 1'b1;
      irq_event     <= 1'b0;
    end else begin
      line_prev_reg <= irq_line_in;
      irq_event     <= line_prev_reg & ~irq_line_in;
    end
  end

  // Data reads return pin levels, masked.
  always_comb begin
    rdata_next = WORD_ZERO;
    if (paddr == OFS_DATA) begin
      rdata_next = widen(pin_level);
    end else if (paddr == OFS_IRQ_EN) begin
      rdata_next = widen(irq_en_reg);
    end else if (paddr == OFS_DRIVE_LOW) begin
      rdata_next = widen(dm_low_reg);
    end else if (paddr == OFS_DRIVE_HIGH) begin
      rdata_next = widen(dm_high_reg);
    end else if (paddr == OFS_BYPASS_SEL) begin
      rdata_next = widen(bypass_reg);
    end else if (paddr == OFS_IO_CONFIG) begin
      rdata_next = {31'h0000_0000, change_sel_reg};
    end else if (paddr == OFS_IRQ_STATUS) begin
      rdata_next = widen(irq_assert);
    end
  end

  // Zero-wait slave, so read data must be combinational to land in the access cycle.
  assign prdata = rd_en ? rdata_next : WORD_ZERO;

  AST_DISABLED_QUIET: assert property (@(posedge clock) disable iff (reset)
    (irq_en_reg == 8'h00) |-> !irq_line_oe) else $error("line pulled with no enables");
  AST_LEVEL_MODE: assert property (@(posedge clock) disable iff (reset)
    (!change_sel_reg && (irq_en_reg & LIVE_MASK & ~pin_level) != 8'h00) |-> irq_line_oe)
    else $error("level mode low pin not asserting");
  AST_CHANGE_RELEASE: assert property (@(posedge clock) disable iff (reset)
    (change_sel_reg && data_read && $stable(pin_level)) |=> (irq_assert == 8'h00))
    else $error("read in change mode did not release");
  AST_EVENT_EDGE: assert property (@(posedge clock) disable iff (reset)
    $fell(irq_line_in) |=> irq_event) else $error("missing shared interrupt pulse");
  AST_NO_EVENT_LOW: assert property (@(posedge clock) disable iff (reset)
    (!irq_line_in && $past(irq_line_in) == 1'b0) |=> !irq_event) else $error("event while held");
  AST_DATA_DRIVE: assert property (@(posedge clock) disable iff (reset)
    (wr_en && paddr == OFS_DATA && ((bypass_reg | serial_force) == 8'h00)) ##1
    ((bypass_reg | serial_force) == 8'h00) |=> pin_out == ($past(pwdata[7:0], 2) & LIVE_MASK))
    else $error("data write not driven");
  AST_BYPASS: assert property (@(posedge clock) disable iff (reset)
    1'b1 |=> ((pin_out ^ $past(alt_data)) & $past(bypass_reg | serial_force) & LIVE_MASK) == 8'h00)
    else $error("bypass not routed");
  AST_IMMEDIATE: assert property (@(posedge clock) disable iff (reset)
    (wr_en && paddr == OFS_IRQ_EN && pwdata[0] && LIVE_MASK[0] && !change_sel_reg && !pin_level[0]
     && $stable(pin_level[0])) |=> (irq_assert[0] || pin_level[0] || change_sel_reg))
    else $error("enable did not assert at once");
  AST_UNUSED_ZERO: assert property (@(posedge clock) disable iff (reset)
    rd_en |-> ((prdata[7:0] & ~LIVE_MASK) == 8'h00)) else $error("unimplemented bit read one");

  COV_LEVEL_IRQ: cover property (@(posedge clock) disable iff (reset) !change_sel_reg ##1 irq_event);
  COV_CHANGE_IRQ: cover property (@(posedge clock) disable iff (reset) change_sel_reg && irq_line_oe ##1 data_read);
  COV_BYPASS: cover property (@(posedge clock) disable iff (reset) serial_force != 8'h00);
endmodule : gpio_port

// [gpio_port_pkg.sv]
// Package with register map, field positions and reset values of the GPIO port.
package gpio_port_pkg;
  localparam int          ADDR_W          = 8;
  localparam logic [7:0]  OFS_DATA        = 8'h00;
  localparam logic [7:0]  OFS_IRQ_EN      = 8'h04;
  localparam logic [7:0]  OFS_DRIVE_LOW   = 8'h08;
  localparam logic [7:0]  OFS_DRIVE_HIGH  = 8'h0c;
  localparam logic [7:0]  OFS_BYPASS_SEL  = 8'h10;
  localparam logic [7:0]  OFS_IO_CONFIG   = 8'h14;
  localparam logic [7:0]  OFS_IRQ_STATUS  = 8'h18;
  localparam int          CHANGE_SEL_BIT  = 0;
  localparam logic [7:0]  RST_ZERO        = 8'h00;
  localparam logic [7:0]  RST_DRIVE_HIGH  = 8'hff;
  localparam logic [1:0]  DM_ANALOG_HIZ   = 2'h2;
  localparam logic [1:0]  DM_OPEN_DRAIN   = 2'h3;
  localparam logic [1:0]  DM_RES_PULLUP   = 2'h0;
  localparam logic [31:0] WORD_ZERO       = 32'h0000_0000;
endpackage : gpio_port_pkg

// [gpio_pin_slice.sv]
// One pin's synchroniser, last-read latch and open-drain interrupt drive.
`timescale 1ns/1ps
module gpio_pin_slice
  import gpio_port_pkg::*;
(
  input  wire logic       clock,        // System clock.
  input  wire logic       reset,        // Synchronous reset, active high.
  input  wire logic       pin_raw,      // Raw pin level.
  input  wire logic [1:0] drive_mode,   // Drive mode of this pin.
  input  wire logic       irq_en,       // Pin interrupt enable.
  input  wire logic       change_sel,   // Chip-wide change mode.
  input  wire logic       data_read,    // Data register read strobe.
  output logic            pin_level,    // Synchronised digital level.
  output logic            irq_assert,   // Interrupt condition met.
  output logic            irq_out_n_oe  // Open-drain pull-low enable.
);
  logic sync1_reg;
  logic sync2_reg;
  logic last_read_reg;

  always_ff @(posedge clock) begin
    if (reset) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end else begin
      sync1_reg <= pin_raw;
      sync2_reg <= sync1_reg;
    end
  end

  assign pin_level = (drive_mode == DM_ANALOG_HIZ) ? 1'b0 : sync2_reg;

  always_ff @(posedge clock) begin
    if (reset) begin
      last_read_reg <= 1'b0;
    end else if (data_read) begin
      last_read_reg <= pin_level;
    end
  end

  // Condition is combinational, so it follows each cause at once.
  assign irq_assert   = irq_en & (change_sel ? (pin_level != last_read_reg) : ~pin_level);
  assign irq_out_n_oe = irq_assert;
endmodule : gpio_pin_slice

// [gpio_board.sv]
// Board model: pin loading, external drivers and the shared interrupt wire.
`timescale 1ns/1ps
module gpio_board (
  input  wire logic [7:0] pin_out,    // Port output data.
  input  wire logic [7:0] dm_low,     // Drive mode bit 0.
  input  wire logic [7:0] dm_high,    // Drive mode bit 1.
  input  wire logic [7:0] ext_en,     // External driver active.
  input  wire logic [7:0] ext_val,    // External driver level.
  input  wire logic       irq_o,      // Port line value.
  input  wire logic       irq_oe,     // Port pulls the line.
  input  wire logic       other_pull, // Another port pulls the line.
  output logic      [7:0] pin_in,     // Resolved pin levels.
  output logic            irq_in      // Resolved shared line.
);
  // Strong drive wins, a driven low beats the board pull-up, otherwise an external driver or the pull-up.
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if ({dm_high[i], dm_low[i]} == 2'h1) pin_in[i] = pin_out[i];
      else if (!pin_out[i] && {dm_high[i], dm_low[i]} != 2'h2) pin_in[i] = 1'b0;
      else pin_in[i] = ext_en[i] ? ext_val[i] : 1'b1;
    end
  end
  assign irq_in = !((irq_oe && !irq_o) || other_pull);
endmodule : gpio_board

// [gpio_port_tb.sv]
// Self-checking bench for the GPIO port: registers, bypass and pin interrupts.
`timescale 1ns/1ps
module gpio_port_tb import gpio_port_pkg::*;;
  localparam logic [7:0] MASK = 8'hdf; // Pin 5 is left out.
  logic              clock, reset, psel, penable, pwrite, pready, pslverr, er;
  logic              irq_line_in, irq_line_o, irq_line_oe, irq_event, other_pull;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata, rdv;
  logic [7:0]        pin_in, pin_out, dm_lo, dm_hi, serial_force, alt_data, ext_en, ext_val;
  int                mismatches, checked, events;

  gpio_port #(.PIN_COUNT(8), .PIN_MASK(MASK)) gpio_port_i (.clock(clock), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .drive_mode_low_bits(dm_lo),
    .drive_mode_high_bits(dm_hi), .serial_force(serial_force), .alt_data(alt_data),
    .irq_line_in(irq_line_in), .irq_line_o(irq_line_o), .irq_line_oe(irq_line_oe), .irq_event(irq_event));
  gpio_board gpio_board_i (.pin_out(pin_out), .dm_low(dm_lo), .dm_high(dm_hi), .ext_en(ext_en),
    .ext_val(ext_val), .irq_o(irq_line_o), .irq_oe(irq_line_oe), .other_pull(other_pull),
    .pin_in(pin_in), .irq_in(irq_line_in));

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // Counting pulses keeps the one-cycle event from being missed between checks.
  always @(posedge clock) if (irq_event === 1'b1) events <= events + 1;

  task automatic give_verdict;
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      mismatches++;
      give_verdict();
    end else begin
      rdv = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdv, exp);
  endtask : rd

  task automatic settle;
    repeat (5) @(posedge clock);
  endtask : settle

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask : done

  initial begin
    {reset, psel, penable, pwrite, other_pull} = 5'h10;
    {paddr, pwdata, serial_force, alt_data, ext_en, ext_val} = '0;
    {mismatches, checked, events} = '0;
    repeat (20) @(posedge clock);
    reset <= 1'b0;
    rd(OFS_DRIVE_HIGH, {24'h0, RST_DRIVE_HIGH & MASK});
    rd(OFS_IRQ_EN, 32'h0);
    apb(1'b0, 8'h1c, 32'h0);
    chk(rdv, 32'h0);
    chk(er, 1'b1);
    done("reset");
    apb(1'b1, OFS_IO_CONFIG, 32'h0);
    apb(1'b1, OFS_DRIVE_LOW, 32'hff);
    apb(1'b1, OFS_DRIVE_HIGH, 32'hff);
    apb(1'b1, OFS_DATA, 32'h96);
    settle;
    chk(pin_out, 8'h96);
    alt_data <= 8'h01;
    apb(1'b1, OFS_BYPASS_SEL, 32'h03);
    settle;
    chk(pin_out, 8'h95);
    serial_force <= 8'h80;
    settle;
    chk(pin_out, 8'h15);
    serial_force <= 8'h00;
    apb(1'b1, OFS_BYPASS_SEL, 32'h0);
    apb(1'b1, OFS_DATA, 32'hdf);
    settle;
    rd(OFS_DATA, 32'hdf);
    ext_en <= 8'h04;
    settle;
    rd(OFS_DATA, 32'hdb);
    apb(1'b1, OFS_DRIVE_LOW, 32'hf7);
    settle;
    rd(OFS_DATA, 32'hd3);
    apb(1'b1, OFS_DRIVE_LOW, 32'hff);
    done("data");
    settle;
    chk(irq_line_oe, 1'b0);
    apb(1'b1, OFS_IRQ_EN, 32'h04);
    // The enable lands at the access edge, so look one edge later.
    @(posedge clock);
    chk(irq_line_oe, 1'b1);
    settle;
    chk(events, 1);
    rd(OFS_IRQ_EN, 32'h04);
    apb(1'b1, OFS_IRQ_EN, 32'hff);
    rd(OFS_IRQ_EN, {24'h0, MASK});
    apb(1'b1, OFS_IRQ_EN, 32'h0);
    settle;
    chk(irq_line_oe, 1'b0);
    done("level");
    apb(1'b1, OFS_IO_CONFIG, 32'h1);
    apb(1'b1, OFS_IRQ_EN, 32'h04);
    settle;
    chk(irq_line_oe, 1'b0);
    ext_en <= 8'h00;
    settle;
    chk(irq_line_oe, 1'b1);
    apb(1'b1, OFS_IO_CONFIG, 32'h0);
    settle;
    chk(irq_line_oe, 1'b0);
    apb(1'b1, OFS_IO_CONFIG, 32'h1);
    rd(OFS_DATA, 32'hdf);
    settle;
    chk(irq_line_oe, 1'b0);
    ext_en <= 8'h04;
    settle;
    chk(irq_line_oe, 1'b1);
    rd(OFS_DATA, 32'hdb);
    settle;
    chk(irq_line_oe, 1'b0);
    // Returning to change mode with a stale latch pulls the line once more.
    chk(events, 4);
    done("change");
    other_pull <= 1'b1;
    settle;
    chk(events, 5);
    ext_en <= 8'h00;
    settle;
    chk(irq_line_oe, 1'b1);
    other_pull <= 1'b0;
    settle;
    chk(events, 5);
    done("wire_or");
    give_verdict();
  end
endmodule : gpio_port_tb
